// [verilog/rot_exec_defines.svh]
// Register offsets, field positions, encodings and reset values of the execute unit
`ifndef ROT_EXEC_DEFINES_SVH
`define ROT_EXEC_DEFINES_SVH
`define REG_INSN 4'h0
`define REG_WORK 4'h1
`define REG_BANK 4'h2
`define REG_FLAGS 4'h3
`define REG_FADDR 4'h4
`define REG_FDATA 4'h5
`define REG_STAT 4'h6
`define STAT_BUSY 0
`define STAT_ILL 1
`define OPC6_RLN 6'h11
`define OPC6_RRC 6'h0C
`define OPC6_RRN 6'h10
`define OPC7_SET 7'h34
`define BIT_DEST 9
`define BIT_BANKED 8
`define ALL_ONES 8'hFF
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define PHASES_PER_CYCLE 4
`endif

// [verilog/rot_exec_pkg.sv]
// Types shared by the rotate and set execute unit
package rot_exec_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;
  typedef enum logic [2:0] {OP_NONE, OP_RLN, OP_RRC, OP_RRN, OP_SET} op_e;
  typedef struct packed {
    op_e op;
    logic dest_f;
    logic banked;
    logic [7:0] faddr;
  } insn_s;
  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } flags_s;
endpackage : rot_exec_pkg

// [verilog/rotate_alu.sv]
// Combinational rotate and set datapath with flag results
`timescale 1ns/1ps
`include "rot_exec_defines.svh"
module rotate_alu (
  // Operation and operand
  input wire rot_exec_pkg::op_e op,
  input wire logic [7:0] opnd,
  input wire rot_exec_pkg::flags_s flags_in,
  // Result
  output logic [7:0] result,
  output rot_exec_pkg::flags_s flags_out
);
  always_comb begin
    result = opnd;
    flags_out = flags_in;
    case (op)
      rot_exec_pkg::OP_RLN: result = {opnd[6:0], opnd[7]};
      rot_exec_pkg::OP_RRC: begin
        result = {flags_in.c, opnd[7:1]};
        flags_out.c = opnd[0];
      end
      rot_exec_pkg::OP_RRN: result = {opnd[0], opnd[7:1]};
      rot_exec_pkg::OP_SET: result = `ALL_ONES;
      default: result = opnd;
    endcase
    // Set leaves every flag alone; the rotates all refresh N and Z
    if (op != rot_exec_pkg::OP_SET && op != rot_exec_pkg::OP_NONE) begin
      flags_out.z = (result == 8'h00);
      flags_out.n = result[7];
    end
  end
endmodule : rotate_alu

// [verilog/rotate_and_set_execute_unit.sv]
// Four-phase execute unit for file-register rotate and set instructions
`timescale 1ns/1ps
`include "rot_exec_defines.svh"
module rotate_and_set_execute_unit #(
  parameter int BSR_W = 4,
  parameter logic [BSR_W-1:0] ACCESS_BANK = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Status
  output logic busy
);
  localparam int FA_W = BSR_W + 8;
  localparam int DEPTH = 1 << FA_W;

  // File register space, written by software when idle and by phase 4
  logic [7:0] mem [DEPTH];

  rot_exec_pkg::phase_e st_q, st_d;
  rot_exec_pkg::insn_s dec_q, dec_d;
  rot_exec_pkg::flags_s flags_q, flags_d, alu_flags;
  logic [15:0] raw_q, raw_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d, alu_res;
  logic [7:0] working_register_q, working_register_d;
  logic [BSR_W-1:0] bsr_q, bsr_d;
  logic [FA_W-1:0] sw_fa_q, sw_fa_d;
  logic ill_q, ill_d;
  logic [15:0] rdata_q, rdata_d;
  logic [BSR_W-1:0] bank;
  logic [FA_W-1:0] ea;
  logic mem_we;
  logic [FA_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic idle;
  logic is_rot;
  rot_exec_pkg::insn_s dec_raw;

  assign idle = (st_q == rot_exec_pkg::PH_IDLE);
  assign busy = !idle;
  assign rdata = rdata_q;
  assign is_rot = (dec_q.op == rot_exec_pkg::OP_RLN) || (dec_q.op == rot_exec_pkg::OP_RRC) ||
                  (dec_q.op == rot_exec_pkg::OP_RRN);

  // Bank resolution uses the live bank register; software cannot change it mid-instruction
  assign bank = dec_q.banked ? bsr_q : ACCESS_BANK;
  assign ea = {bank, dec_q.faddr};

  // Instruction decode from the raw word
  always_comb begin
    dec_raw.op = rot_exec_pkg::OP_NONE;
    dec_raw.dest_f = raw_q[`BIT_DEST];
    dec_raw.banked = raw_q[`BIT_BANKED];
    dec_raw.faddr = raw_q[7:0];
    if (raw_q[15:10] == `OPC6_RLN) begin
      dec_raw.op = rot_exec_pkg::OP_RLN;
    end else if (raw_q[15:10] == `OPC6_RRC) begin
      dec_raw.op = rot_exec_pkg::OP_RRC;
    end else if (raw_q[15:10] == `OPC6_RRN) begin
      dec_raw.op = rot_exec_pkg::OP_RRN;
    end else if (raw_q[15:9] == `OPC7_SET) begin
      dec_raw.op = rot_exec_pkg::OP_SET;
      dec_raw.dest_f = 1'b1;
    end
  end

  rotate_alu u_alu (
    .op(dec_q.op),
    .opnd(opnd_q),
    .flags_in(flags_q),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  // Next-state logic for the phase sequencer, registers and register port
  always_comb begin
    st_d = st_q;
    dec_d = dec_q;
    raw_d = raw_q;
    opnd_d = opnd_q;
    res_d = res_q;
    working_register_d = working_register_q;
    bsr_d = bsr_q;
    flags_d = flags_q;
    sw_fa_d = sw_fa_q;
    ill_d = ill_q;
    rdata_d = `RST_WORD;
    mem_we = 1'b0;
    mem_wa = sw_fa_q;
    mem_wd = wdata[7:0];
    // Software writes are ignored while an instruction is in flight
    if (wr && idle) begin
      case (addr)
        `REG_INSN: begin
          raw_d = wdata;
          st_d = rot_exec_pkg::PH_Q1;
        end
        `REG_WORK: working_register_d = wdata[7:0];
        `REG_BANK: bsr_d = wdata[BSR_W-1:0];
        `REG_FLAGS: flags_d = wdata[2:0];
        `REG_FADDR: sw_fa_d = wdata[FA_W-1:0];
        `REG_FDATA: mem_we = 1'b1;
        `REG_STAT: begin
          if (wdata[`STAT_ILL]) begin
            ill_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        `REG_INSN: rdata_d = raw_q;
        `REG_WORK: rdata_d = {8'h00, working_register_q};
        `REG_BANK: rdata_d = 16'(bsr_q);
        `REG_FLAGS: rdata_d = {13'h0000, flags_q};
        `REG_FADDR: rdata_d = 16'(sw_fa_q);
        `REG_FDATA: rdata_d = {8'h00, mem[sw_fa_q]};
        `REG_STAT: rdata_d = {14'h0000, ill_q, busy};
        default: rdata_d = `RST_WORD;
      endcase
    end
    case (st_q)
      rot_exec_pkg::PH_IDLE: ;
      rot_exec_pkg::PH_Q1: begin
        dec_d = dec_raw;
        st_d = rot_exec_pkg::PH_Q2;
        // An unknown word is dropped; its flag set wins over a clear
        if (dec_raw.op == rot_exec_pkg::OP_NONE) begin
          ill_d = 1'b1;
          st_d = rot_exec_pkg::PH_IDLE;
        end
      end
      rot_exec_pkg::PH_Q2: begin
        opnd_d = mem[ea];
        st_d = rot_exec_pkg::PH_Q3;
      end
      rot_exec_pkg::PH_Q3: begin
        res_d = alu_res;
        st_d = rot_exec_pkg::PH_Q4;
      end
      rot_exec_pkg::PH_Q4: begin
        flags_d = alu_flags;
        if (dec_q.dest_f) begin
          mem_we = 1'b1;
          mem_wa = ea;
          mem_wd = res_q;
        end else begin
          working_register_d = res_q;
        end
        st_d = rot_exec_pkg::PH_IDLE;
      end
      default: st_d = rot_exec_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= rot_exec_pkg::PH_IDLE;
      dec_q <= '0;
      raw_q <= `RST_WORD;
      opnd_q <= `RST_BYTE;
      res_q <= `RST_BYTE;
      working_register_q <= `RST_BYTE;
      bsr_q <= '0;
      flags_q <= '0;
      sw_fa_q <= '0;
      ill_q <= 1'b0;
      rdata_q <= `RST_WORD;
    end else begin
      st_q <= st_d;
      dec_q <= dec_d;
      raw_q <= raw_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      working_register_q <= working_register_d;
      bsr_q <= bsr_d;
      flags_q <= flags_d;
      sw_fa_q <= sw_fa_d;
      ill_q <= ill_d;
      rdata_q <= rdata_d;
    end
  end

  // Memory has no reset; its content is undefined until written
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic start;
  assign start = wr && idle && (addr == `REG_INSN);

  property p_one_cycle;
    start |=> st_q == rot_exec_pkg::PH_Q1 ##1 st_q != rot_exec_pkg::PH_Q1 ##1 1'b1 ##1 1'b1 ##1 idle;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction did not finish in four phases");

  property p_phase_order;
    (st_q == rot_exec_pkg::PH_Q2) |-> $past(st_q) == rot_exec_pkg::PH_Q1 ##1
      st_q == rot_exec_pkg::PH_Q3 ##1 st_q == rot_exec_pkg::PH_Q4;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken");

  property p_rln;
    (st_q == rot_exec_pkg::PH_Q3 && dec_q.op == rot_exec_pkg::OP_RLN) |=> res_q == {opnd_q[6:0], opnd_q[7]};
  endproperty
  a_rln: assert property (p_rln) else $error("rotate left plain result wrong");

  property p_rrc;
    (st_q == rot_exec_pkg::PH_Q4 && dec_q.op == rot_exec_pkg::OP_RRC) |=>
      flags_q.c == opnd_q[0] && res_q == {$past(flags_q.c), opnd_q[7:1]};
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate via carry wrong");

  property p_rrn;
    (st_q == rot_exec_pkg::PH_Q4 && dec_q.op == rot_exec_pkg::OP_RRN) |=>
      $stable(flags_q.c) && res_q == {opnd_q[0], opnd_q[7:1]};
  endproperty
  a_rrn: assert property (p_rrn) else $error("rotate right plain wrong");

  property p_set;
    (st_q == rot_exec_pkg::PH_Q4 && dec_q.op == rot_exec_pkg::OP_SET) |->
      mem_we && mem_wd == `ALL_ONES && mem_wa == ea ##1 $stable(flags_q);
  endproperty
  a_set: assert property (p_set) else $error("set all ones wrong");

  property p_dest_w;
    (st_q == rot_exec_pkg::PH_Q4 && is_rot && !dec_q.dest_f) |-> !mem_we ##1 working_register_q == $past(res_q);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("working register destination wrong");

  property p_dest_f;
    (st_q == rot_exec_pkg::PH_Q4 && is_rot && dec_q.dest_f) |-> mem_we && mem_wa == ea ##1 $stable(working_register_q);
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("file destination wrong");

  // Checked against the raw word so that a decode slip on the access bit shows up too
  property p_bank_fixed;
    (st_q == rot_exec_pkg::PH_Q2 && !raw_q[`BIT_BANKED]) |->
      ea == {ACCESS_BANK, raw_q[7:0]};
  endproperty
  a_bank_fixed: assert property (p_bank_fixed) else $error("fixed bank address wrong");

  property p_bank_sel;
    (st_q == rot_exec_pkg::PH_Q2 && raw_q[`BIT_BANKED]) |->
      ea == {bsr_q, raw_q[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("selected bank address wrong");

  property p_dec_rln;
    (st_q == rot_exec_pkg::PH_Q1 && raw_q[15:10] == `OPC6_RLN) |=>
      dec_q.op == rot_exec_pkg::OP_RLN && dec_q.dest_f == raw_q[`BIT_DEST] && dec_q.faddr == raw_q[7:0];
  endproperty
  a_dec_rln: assert property (p_dec_rln) else $error("rotate left plain decode wrong");

  property p_dec_rrc;
    (st_q == rot_exec_pkg::PH_Q1 && raw_q[15:10] == `OPC6_RRC) |=>
      dec_q.op == rot_exec_pkg::OP_RRC && dec_q.dest_f == raw_q[`BIT_DEST] && dec_q.faddr == raw_q[7:0];
  endproperty
  a_dec_rrc: assert property (p_dec_rrc) else $error("rotate via carry decode wrong");

  property p_dec_rrn;
    (st_q == rot_exec_pkg::PH_Q1 && raw_q[15:10] == `OPC6_RRN) |=>
      dec_q.op == rot_exec_pkg::OP_RRN && dec_q.dest_f == raw_q[`BIT_DEST] && dec_q.faddr == raw_q[7:0];
  endproperty
  a_dec_rrn: assert property (p_dec_rrn) else $error("rotate right plain decode wrong");

  property p_dec_set;
    (st_q == rot_exec_pkg::PH_Q1 && raw_q[15:9] == `OPC7_SET) |=>
      dec_q.op == rot_exec_pkg::OP_SET && dec_q.dest_f && dec_q.banked == raw_q[`BIT_BANKED];
  endproperty
  a_dec_set: assert property (p_dec_set) else $error("set all ones decode wrong");

  property p_nz;
    (st_q == rot_exec_pkg::PH_Q4 && is_rot) |=> flags_q.z == ($past(res_q) == 8'h00) && flags_q.n == $past(res_q[7]);
  endproperty
  a_nz: assert property (p_nz) else $error("zero or negative flag wrong");

  c_rrc_file: cover property (st_q == rot_exec_pkg::PH_Q4 && dec_q.op == rot_exec_pkg::OP_RRC && dec_q.dest_f);
  c_rln_work: cover property (st_q == rot_exec_pkg::PH_Q4 && dec_q.op == rot_exec_pkg::OP_RLN && !dec_q.dest_f);
  c_set_bank: cover property (st_q == rot_exec_pkg::PH_Q4 && dec_q.op == rot_exec_pkg::OP_SET && dec_q.banked);
  c_illegal: cover property (st_q == rot_exec_pkg::PH_Q1 && dec_raw.op == rot_exec_pkg::OP_NONE);
endmodule : rotate_and_set_execute_unit

// [test/tb_top.sv]
// Self-checking bench for the rotate and set execute unit
`timescale 1ns/1ps
module tb_top;
  logic clock;
  logic rstn;
  logic wr;
  logic rd;
  logic busy;
  logic rd_pend;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] expq[$];
  logic [5:0] opc [3] = '{6'h11, 6'h0C, 6'h10};
  int num_errors;
  int checked;
  int seed;
  int n;

  rotate_and_set_execute_unit dut (
    .clock(clock),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .busy(busy)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("Errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // One idle edge after each strobe keeps a driver from assigning a strobe twice per step
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(exp);
    @(posedge clock);
    rd <= 1'b0;
  endtask : rd_reg

  // Read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge clock) rd_pend <= rd;
  always @(negedge clock) begin
    if (rd_pend === 1'b1) begin
      chk(rdata, expq.pop_front());
    end
  end

  task automatic exec(input logic [15:0] insn, input int cycles);
    wr_reg(4'h0, insn);
    n = 0;
    repeat (8) begin
      @(negedge clock);
      if (busy === 1'b1) n++;
    end
    chk(16'(n), 16'(cycles));
  endtask : exec

  function automatic logic [10:0] model(input int op, input logic [7:0] v, input logic [2:0] fl);
    logic [7:0] r;
    logic c;
    c = fl[0];
    case (op)
      0: r = {v[6:0], v[7]};
      1: begin
        r = {fl[0], v[7:1]};
        c = v[0];
      end
      2: r = {v[0], v[7:1]};
      default: return {fl, 8'hFF};
    endcase
    return {r[7], r == 8'h00, c, r};
  endfunction : model

  initial begin
    logic [7:0] f, v, w0, bank_select_register, decoy;
    logic [2:0] fl;
    logic [10:0] m;
    logic [11:0] tgt, oth;
    logic [15:0] insn;
    logic d, a;
    int op;
    seed = 22257;
    num_errors = 0;
    checked = 0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    // Every operation with every destination and bank choice, twice
    for (int i = 0; i < 32; i++) begin
      op = i % 4;
      d = i[2];
      a = i[3];
      bank_select_register = 8'(1 + {$random(seed)} % 15);
      f = 8'($random(seed));
      v = (i % 7 == 0) ? 8'h00 : 8'($random(seed));
      w0 = 8'($random(seed));
      fl = 3'($random(seed));
      decoy = ~v;
      tgt = {a ? bank_select_register[3:0] : 4'h0, f};
      oth = {a ? 4'h0 : bank_select_register[3:0], f};
      wr_reg(4'h2, 16'(bank_select_register));
      wr_reg(4'h1, 16'(w0));
      wr_reg(4'h3, 16'(fl));
      wr_reg(4'h4, 16'(oth));
      wr_reg(4'h5, 16'(decoy));
      wr_reg(4'h4, 16'(tgt));
      wr_reg(4'h5, 16'(v));
      insn = (op == 3) ? {7'h34, a, f} : {opc[op], d, a, f};
      exec(insn, 4);
      m = model(op, v, fl);
      rd_reg(4'h1, 16'((op != 3 && !d) ? m[7:0] : w0));
      rd_reg(4'h3, 16'(m[10:8]));
      rd_reg(4'h5, 16'((op == 3 || d) ? m[7:0] : v));
      wr_reg(4'h4, 16'(oth));
      rd_reg(4'h5, 16'(decoy));
      rd_reg(4'h0, insn);
    end
    // A write that lands while an instruction runs is dropped
    wr_reg(4'h1, 16'h005A);
    wr_reg(4'h0, {6'h10, 2'b11, f});
    wr_reg(4'h1, 16'h00A5);
    rd_reg(4'h6, 16'h0001);
    repeat (6) @(negedge clock);
    rd_reg(4'h1, 16'h005A);
    // Unknown opcode ends after decode and sets the sticky flag
    exec(16'hFFFF, 1);
    rd_reg(4'h6, 16'h0002);
    wr_reg(4'h6, 16'h0002);
    rd_reg(4'h6, 16'h0000);
    wr_reg(4'h9, 16'h1234);
    rd_reg(4'h9, 16'h0000);
    repeat (3) @(negedge clock);
    conclude();
  end

  // Whole run needs about 1200 cycles; this cuts a hang well beyond that
  initial begin
    #1000000;
    num_errors++;
    conclude();
  end
endmodule : tb_top
